// *** hw/csc_pkg.sv ***
// constants and types for the charger supply control block
package csc_pkg;
	// register byte addresses
	localparam logic [7:0] CSC_CTRL_ADDR   = 8'h00;
	localparam logic [7:0] CSC_LIMIT_ADDR  = 8'h04;
	localparam logic [7:0] CSC_CHARGE_ADDR = 8'h08;
	localparam logic [7:0] CSC_RAIL_ADDR   = 8'h0c;
	localparam logic [7:0] CSC_STATUS_ADDR = 8'h10;
	// control register bit positions
	localparam int CSC_CTRL_REG_BIT = 0;
	localparam int CSC_CTRL_CHG_BIT = 1;
	localparam int CSC_CTRL_DPM_BIT = 2;
	localparam int CSC_CTRL_CLR_BIT = 3;
	// field positions inside the code registers
	localparam int CSC_COLLAPSE_LSB = 8;
	localparam int CSC_VOLT_LSB     = 8;
	localparam int CSC_DROPOUT_LSB  = 8;
	// one-time-programmed defaults; input limit, collapse, current and voltage are used while the device is off
	localparam logic [5:0] CSC_DEF_INPUT_LIMIT = 6'h05;
	localparam logic [2:0] CSC_DEF_COLLAPSE    = 3'h3;
	localparam logic [3:0] CSC_DEF_CUR         = 4'h4;
	localparam logic [5:0] CSC_DEF_VOLT        = 6'h20;
	localparam logic [5:0] CSC_DEF_RAIL        = 6'h18;
	localparam logic [1:0] CSC_DEF_DROPOUT     = 2'h1;
	localparam logic [6:0] CSC_PRECHARGE_RAIL  = 7'h18;
	// charging phases reported by the analog charger
	localparam logic [1:0] CSC_PH_PRECOND = 2'h0;
	localparam logic [1:0] CSC_PH_PRECHG  = 2'h1;
	localparam logic [1:0] CSC_PH_FULL    = 2'h2;
	localparam logic [1:0] CSC_PH_EOC     = 2'h3;
	// power control states
	typedef enum logic {CSC_OFF, CSC_ON} csc_pwr_t;
endpackage

// *** hw/csc_supply_ctrl.sv ***
// startup, fallback and charger control for the supply regulator
// Behaviour
// - topology bit one selects power-path operation
// - topology bit zero uses battery as rail
// - charge bit picks hardware or software control
// - power-path starts when rail exceeds startup
// - non-power-path starts when battery exceeds startup
// - hardware power-path auto-starts regulation and charging
// - hardware non-power-path auto-starts charging
// - standard port with good battery: no auto-start; software mode still runs the charger while off
// - undervoltage shuts down and sets fallback flag
// - repeated fallback disables regulation and charging
// - fallback restart needs restart or startup level
// - software mode off: device applies default codes
// - rail target fixed or tracking battery
// - rail at precharge level, then battery plus dropout
// - dynamic loop keeps headroom at half dropout
// - power-path preconditioning uses internal current source
// - charge current and voltage codes limit battery
// - input current limited by six-bit code
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module csc_supply_ctrl
	import csc_pkg::*;
(
	input  wire logic        sys_clk,            // 100 mhz clock
	input  wire logic        sys_rst,            // sync reset, high
	input  wire logic [7:0]  addr,               // register byte address
	input  wire logic [31:0] wdata,              // write data
	input  wire logic        wr,                 // write strobe
	input  wire logic        rd,                 // read strobe
	output logic      [31:0] rdata,              // read data, next cycle
	input  wire logic        power_path_select,  // topology strap
	input  wire logic        hw_charge_select,   // charge control strap
	input  wire logic        vbus_present,       // vbus detected
	input  wire logic        ac_charger_input,   // ac charger detected
	input  wire logic        charging_port,      // usb charging port
	input  wire logic        sys_above_startup,  // rail over startup
	input  wire logic        bat_above_startup,  // battery over startup
	input  wire logic        bat_above_restart,  // battery over restart
	input  wire logic        sys_below_shutdown, // rail under shutdown
	input  wire logic        bat_below_shutdown, // battery under shutdown
	input  wire logic [1:0]  charge_phase,       // analog charge phase
	input  wire logic [5:0]  vbat_code,          // battery voltage code
	input  wire logic [2:0]  headroom_code,      // rail minus battery
	output logic             dev_on_q,           // device powered on
	output logic             fallback_q,         // fallback flag
	output logic             path_fet_en_q,      // external fet in use
	output logic             reg_en_q,           // rail regulator on
	output logic             chg_en_q,           // battery charger on
	output logic             isrc_en_q,          // precondition source
	output logic      [5:0]  in_lim_q,           // input current code
	output logic      [2:0]  collapse_q,         // collapse level code
	output logic      [3:0]  chg_cur_q,          // charge current code
	output logic      [5:0]  chg_volt_q,         // charge voltage code
	output logic      [6:0]  rail_target_q       // rail target code
);
	csc_pwr_t    state_q;
	csc_pwr_t    state_d;
	logic        strap_done_q;
	logic        pp_q;
	logic        hw_q;
	logic        lock_q;
	logic        host_reg_q;
	logic        host_chg_q;
	logic        dpm_q;
	logic [5:0]  lim_q;
	logic [2:0]  col_q;
	logic [3:0]  cur_q;
	logic [5:0]  volt_q;
	logic [5:0]  rail_q;
	logic [1:0]  drop_q;
	logic        src;
	logic        auto_src;
	logic        start_ok;
	logic        restart_ok;
	logic        under_v;
	logic        auto_run;
	logic        reg_en_d;
	logic        chg_en_d;
	logic        clr_fb;
	logic        shut;
	logic        head_low;
	logic [3:0]  cur_sel;
	logic [6:0]  rail_d;

	// straps caught once, on the first edge after reset release
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			strap_done_q <= 1'b0;
			pp_q         <= 1'b0;
			hw_q         <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			pp_q         <= power_path_select;
			hw_q         <= hw_charge_select;
		end
	end

	// comparator selection by topology
	assign src        = vbus_present | ac_charger_input;
	assign auto_src   = charging_port | ac_charger_input;
	assign start_ok   = pp_q ? sys_above_startup
	                         : bat_above_startup;
	assign restart_ok = pp_q ? bat_above_restart
	                         : bat_above_startup;
	assign under_v    = pp_q ? sys_below_shutdown : bat_below_shutdown;
	assign shut       = (state_q == CSC_ON) && under_v;
	assign clr_fb     = wr && (addr == CSC_CTRL_ADDR) &&
	                    wdata[CSC_CTRL_CLR_BIT];

	// power control next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			CSC_OFF: begin
				if (strap_done_q && src && start_ok &&
				    (!fallback_q || restart_ok)) begin
					state_d = CSC_ON;
				end
			end
			CSC_ON: begin
				if (under_v) begin
					state_d = CSC_OFF;
				end
			end
			default: state_d = CSC_OFF;
		endcase
	end

	// power state and its output copy
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q  <= CSC_OFF;
			dev_on_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			dev_on_q <= (state_d == CSC_ON);
		end
	end

	// fallback flag: shutdown sets, host write clears, set wins
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fallback_q <= 1'b0;
		end else if (shut) begin
			fallback_q <= 1'b1;
		end else if (clr_fb) begin
			fallback_q <= 1'b0;
		end
	end

	// lockout after a second fallback, lifted by the next startup
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lock_q <= 1'b0;
		end else if (shut && fallback_q) begin
			lock_q <= 1'b1;
		end else if (state_d == CSC_ON && state_q == CSC_OFF) begin
			lock_q <= 1'b0;
		end
	end

	// host register writes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			host_reg_q <= 1'b0;
			host_chg_q <= 1'b0;
			dpm_q      <= 1'b0;
			lim_q      <= CSC_DEF_INPUT_LIMIT;
			col_q      <= CSC_DEF_COLLAPSE;
			cur_q      <= CSC_DEF_CUR;
			volt_q     <= CSC_DEF_VOLT;
			rail_q     <= CSC_DEF_RAIL;
			drop_q     <= CSC_DEF_DROPOUT;
		end else if (wr) begin
			case (addr)
				CSC_CTRL_ADDR: begin
					host_reg_q <= wdata[CSC_CTRL_REG_BIT];
					host_chg_q <= wdata[CSC_CTRL_CHG_BIT];
					dpm_q      <= wdata[CSC_CTRL_DPM_BIT];
				end
				CSC_LIMIT_ADDR: begin
					lim_q <= wdata[5:0];
					col_q <= wdata[CSC_COLLAPSE_LSB +: 3];
				end
				CSC_CHARGE_ADDR: begin
					cur_q  <= wdata[3:0];
					volt_q <= wdata[CSC_VOLT_LSB +: 6];
				end
				CSC_RAIL_ADDR: begin
					rail_q <= wdata[5:0];
					drop_q <= wdata[CSC_DROPOUT_LSB +: 2];
				end
				default: ;
			endcase
		end
	end

	// register reads, answered in the following cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				CSC_CTRL_ADDR:   rdata <= {29'h0, dpm_q, host_chg_q,
				                           host_reg_q};
				CSC_LIMIT_ADDR:  rdata <= {21'h0, col_q, 2'h0, lim_q};
				CSC_CHARGE_ADDR: rdata <= {18'h0, volt_q, 4'h0, cur_q};
				CSC_RAIL_ADDR:   rdata <= {22'h0, drop_q, 2'h0, rail_q};
				CSC_STATUS_ADDR: rdata <= {25'h0, lock_q, hw_q, pp_q,
				                           chg_en_q, reg_en_q, fallback_q,
				                           dev_on_q};
				default:         rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// which runs the hardware starts on its own
	always_comb begin
		if (hw_q) begin
			// charging port, ac, or a low battery while off
			auto_run = auto_src ||
			           ((state_q == CSC_OFF) && !bat_above_restart);
		end else begin
			auto_run = (state_q == CSC_OFF);
		end
	end

	// regulator and charger enables
	always_comb begin
		reg_en_d = 1'b0;
		chg_en_d = 1'b0;
		if (strap_done_q && src && !lock_q) begin
			reg_en_d = pp_q && (auto_run || host_reg_q);
			chg_en_d = auto_run || host_chg_q;
		end
	end

	// dynamic path loop: headroom under half dropout halves current
	assign head_low = {headroom_code, 1'b0} < {2'h0, drop_q};
	assign cur_sel  = (dpm_q && pp_q && head_low) ? {1'b0, cur_q[3:1]}
	                                              : cur_q;

	// rail target: fixed code or tracking the battery
	always_comb begin
		if (dpm_q && pp_q) begin
			if (charge_phase == CSC_PH_PRECOND ||
			    charge_phase == CSC_PH_PRECHG) begin
				rail_d = CSC_PRECHARGE_RAIL;
			end else begin
				rail_d = {1'b0, vbat_code} + {5'h0, drop_q};
			end
		end else begin
			rail_d = {1'b0, rail_q};
		end
	end

	// registered enables and setting codes
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			path_fet_en_q <= 1'b0;
			reg_en_q      <= 1'b0;
			chg_en_q      <= 1'b0;
			isrc_en_q     <= 1'b0;
			in_lim_q      <= CSC_DEF_INPUT_LIMIT;
			collapse_q    <= CSC_DEF_COLLAPSE;
			chg_cur_q     <= CSC_DEF_CUR;
			chg_volt_q    <= CSC_DEF_VOLT;
			rail_target_q <= {1'b0, CSC_DEF_RAIL};
		end else begin
			path_fet_en_q <= pp_q;
			reg_en_q      <= reg_en_d;
			chg_en_q      <= chg_en_d;
			isrc_en_q     <= pp_q && chg_en_d &&
			                 (charge_phase == CSC_PH_PRECOND);
			rail_target_q <= rail_d;
			if (state_q == CSC_OFF) begin
				in_lim_q   <= CSC_DEF_INPUT_LIMIT;
				collapse_q <= CSC_DEF_COLLAPSE;
				chg_cur_q  <= CSC_DEF_CUR;
				chg_volt_q <= CSC_DEF_VOLT;
			end else begin
				in_lim_q   <= lim_q;
				collapse_q <= col_q;
				chg_cur_q  <= cur_sel;
				chg_volt_q <= volt_q;
			end
		end
	end

	// checks on the control behaviour
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	a_fet_topology: assert property (strap_done_q |=> ##1
		path_fet_en_q == $past(pp_q, 2))
		else $error("fet enable does not follow topology");
	a_npp_no_reg: assert property (strap_done_q && !pp_q |=>
		!reg_en_q)
		else $error("regulator on without power path");
	a_pp_startup: assert property (state_q == CSC_OFF &&
		strap_done_q && pp_q && src && sys_above_startup &&
		!fallback_q |=> dev_on_q)
		else $error("power-path startup missed");
	a_npp_startup: assert property (state_q == CSC_OFF &&
		strap_done_q && !pp_q && src && bat_above_startup &&
		!fallback_q |=> dev_on_q)
		else $error("battery startup missed");
	a_shutdown_flag: assert property (shut |=>
		!dev_on_q && fallback_q)
		else $error("shutdown did not set fallback");
	a_lock_off: assert property (shut && fallback_q |=> ##1
		!reg_en_q && !chg_en_q)
		else $error("second fallback left supply running");
	a_fb_hold: assert property (fallback_q && !clr_fb |=>
		fallback_q)
		else $error("fallback flag dropped on its own");
	a_hw_auto: assert property (strap_done_q && hw_q && pp_q &&
		src && auto_src && !lock_q |=> reg_en_q && chg_en_q)
		else $error("hardware auto start missed");
	a_sdp_hold: assert property (strap_done_q && hw_q &&
		!auto_src && (dev_on_q || bat_above_restart) &&
		!host_reg_q && !host_chg_q |=> !reg_en_q && !chg_en_q)
		else $error("hardware started on standard port");
	a_sw_default: assert property (strap_done_q && !hw_q &&
		state_q == CSC_OFF && src && !lock_q |=>
		chg_en_q && in_lim_q == CSC_DEF_INPUT_LIMIT)
		else $error("defaults not applied while off");
	a_rail_track: assert property (dpm_q && pp_q &&
		charge_phase[1] |=> rail_target_q ==
		7'({1'b0, $past(vbat_code)} + {5'h0, $past(drop_q)}))
		else $error("rail not tracking battery");
	a_npp_hw_chg: assert property (strap_done_q && hw_q &&
		!pp_q && src && auto_src && !lock_q |=>
		chg_en_q && !reg_en_q)
		else $error("hardware charge start missed without power path");
	a_restart_block: assert property (state_q == CSC_OFF &&
		fallback_q && !restart_ok |=> !dev_on_q)
		else $error("restart after fallback below restart level");
	a_fb_clear: assert property (clr_fb && !shut |=>
		!fallback_q)
		else $error("host write did not clear fallback");
	a_isrc_precond: assert property (pp_q && chg_en_d &&
		charge_phase == CSC_PH_PRECOND |=> isrc_en_q)
		else $error("precondition source not enabled");
	a_dpm_halve: assert property (dpm_q && pp_q && head_low &&
		state_q == CSC_ON |=> chg_cur_q == ($past(cur_q) >> 1))
		else $error("dynamic loop did not cut charge current");
	a_on_codes: assert property (state_q == CSC_ON |=>
		in_lim_q == $past(lim_q) && collapse_q == $past(col_q) &&
		chg_volt_q == $past(volt_q))
		else $error("host codes not applied while on");
	a_rail_fixed: assert property (!(dpm_q && pp_q) |=>
		rail_target_q == {1'b0, $past(rail_q)})
		else $error("fixed rail code not applied");
	a_precharge_rail: assert property (dpm_q && pp_q &&
		!charge_phase[1] |=> rail_target_q == CSC_PRECHARGE_RAIL)
		else $error("rail not at precharge level");

	c_startup: cover property (state_q == CSC_OFF ##1 dev_on_q);
	c_ac_auto: cover property (ac_charger_input && !dev_on_q ##1 chg_en_q);
	c_fallback: cover property (shut ##[1:50] dev_on_q);
	c_lockout: cover property (shut && fallback_q);
	c_dpm_cut: cover property (dpm_q && pp_q && head_low && dev_on_q);
endmodule

// *** verif/csc_src_model.sv ***
// charging source and level comparator model for the bench
`timescale 1ns/1ps
module csc_src_model #(
	parameter logic [7:0] START_LVL   = 8'h3c, // startup level
	parameter logic [7:0] RESTART_LVL = 8'h37, // restart level
	parameter logic [7:0] SHUT_LVL    = 8'h28  // shutdown level
) (
	input  wire logic [1:0] plug,               // 0 none 1 std 2 chg 3 ac
	input  wire logic [7:0] rail_lvl,           // rail level
	input  wire logic [7:0] bat_lvl,            // battery level
	output logic            vbus_present,       // vbus seen
	output logic            ac_charger_input,   // ac seen
	output logic            charging_port,      // charging port seen
	output logic            sys_above_startup,  // rail over startup
	output logic            bat_above_startup,  // battery over startup
	output logic            bat_above_restart,  // battery over restart
	output logic            sys_below_shutdown, // rail under shutdown
	output logic            bat_below_shutdown  // battery under shutdown
);
	// source detection follows the plugged cable
	assign vbus_present = plug == 2'h1 || plug == 2'h2;
	assign ac_charger_input = plug == 2'h3;
	assign charging_port = plug == 2'h2;
	// comparators, no hysteresis
	assign sys_above_startup = rail_lvl > START_LVL;
	assign bat_above_startup = bat_lvl > START_LVL;
	assign bat_above_restart = bat_lvl > RESTART_LVL;
	assign sys_below_shutdown = rail_lvl < SHUT_LVL;
	assign bat_below_shutdown = bat_lvl < SHUT_LVL;
endmodule

// *** verif/test_charger_supply_control_fsm.sv ***
// self-checking bench for the charger supply control block
`timescale 1ns/1ps
module test_charger_supply_control_fsm;
	import csc_pkg::*;
	logic        sys_clk, sys_rst, wr, rd, pp, hw;
	logic [7:0]  addr, rail_lvl, bat_lvl;
	logic [31:0] wdata, rdata, rv, w;
	logic [1:0]  plug, charge_phase;
	logic [5:0]  vbat_code, in_lim_q, chg_volt_q;
	logic [2:0]  headroom_code, collapse_q;
	logic [3:0]  chg_cur_q;
	logic [6:0]  rail_target_q;
	logic        vbus_present, ac_charger_input, charging_port;
	logic        sys_above_startup, bat_above_startup, bat_above_restart;
	logic        sys_below_shutdown, bat_below_shutdown, dev_on_q;
	logic        fallback_q, path_fet_en_q, reg_en_q, chg_en_q, isrc_en_q;
	int          fails, checked, seed;

	csc_supply_ctrl u_dut (.sys_clk, .sys_rst, .addr, .wdata, .wr, .rd,
		.rdata, .power_path_select(pp), .hw_charge_select(hw),
		.vbus_present, .ac_charger_input, .charging_port,
		.sys_above_startup, .bat_above_startup, .bat_above_restart,
		.sys_below_shutdown, .bat_below_shutdown, .charge_phase,
		.vbat_code, .headroom_code, .dev_on_q, .fallback_q,
		.path_fet_en_q, .reg_en_q, .chg_en_q, .isrc_en_q, .in_lim_q,
		.collapse_q, .chg_cur_q, .chg_volt_q, .rail_target_q);
	csc_src_model u_src (.plug, .rail_lvl, .bat_lvl,
		.vbus_present, .ac_charger_input, .charging_port,
		.sys_above_startup, .bat_above_startup, .bat_above_restart,
		.sys_below_shutdown, .bat_below_shutdown);

	// 100 mhz clock
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	// charge current expected from the dynamic path loop
	function automatic logic [3:0] dyn_cur(logic [3:0] c, logic [2:0] h,
		logic [1:0] d);
		return ({h, 1'b0} < {2'b00, d}) ? c >> 1 : c;
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask
	task automatic lv(input logic [7:0] r, input logic [7:0] b);
		@(posedge sys_clk);
		rail_lvl <= r;
		bat_lvl <= b;
	endtask
	task automatic wait_on(input logic e);
		int n;
		n = 0;
		while (dev_on_q !== e && n < 20) begin
			tick(1);
			n++;
		end
		if (dev_on_q !== e) begin
			fails++;
			$display("BAD %0t power state wait ran out", $time);
			wrap_up();
		end
	endtask
	// host programs codes, then the rail target and dynamic loop
	task automatic codes();
		repeat (6) begin
			w = $random(seed);
			wr_reg(CSC_LIMIT_ADDR, w);
			wr_reg(CSC_CHARGE_ADDR, w);
			tick(2);
			chk(in_lim_q, w[5:0]);
			chk(collapse_q, w[10:8]);
			chk(chg_cur_q, w[3:0]);
			chk(chg_volt_q, w[13:8]);
		end
		wr_reg(CSC_RAIL_ADDR, 32'h0000_0215);
		tick(2);
		chk(rail_target_q, 7'h15);
		wr_reg(CSC_CTRL_ADDR, 32'h7);
		charge_phase <= CSC_PH_PRECOND;
		headroom_code <= 3'h3;
		tick(3);
		chk(rail_target_q, CSC_PRECHARGE_RAIL);
		chk(isrc_en_q, 1'b1);
		@(posedge sys_clk);
		charge_phase <= CSC_PH_PRECHG;
		tick(3);
		chk(rail_target_q, CSC_PRECHARGE_RAIL);
		chk(isrc_en_q, 1'b0);
		@(posedge sys_clk);
		vbat_code <= 6'h20;
		charge_phase <= CSC_PH_FULL;
		tick(3);
		chk(rail_target_q, 7'h22);
		chk(chg_cur_q, dyn_cur(w[3:0], 3'h3, 2'h2));
		@(posedge sys_clk);
		headroom_code <= 3'h0;
		charge_phase <= CSC_PH_EOC;
		tick(3);
		chk(rail_target_q, 7'h22);
		chk(chg_cur_q, dyn_cur(w[3:0], 3'h0, 2'h2));
		wr_reg(CSC_CTRL_ADDR, 32'h3);
	endtask

	initial begin
		seed = 45;
		{wr, rd, addr, wdata, pp, hw, plug, rail_lvl, bat_lvl} = '0;
		{charge_phase, vbat_code, headroom_code} = '0;
		sys_rst = 1'b1;
		for (int m = 0; m < 4; m++) begin
			// each topology and control strap pair after a fresh reset
			@(posedge sys_clk);
			sys_rst <= 1'b1;
			pp <= m[1];
			hw <= m[0];
			plug <= 2'h1;
			lv(m[1] ? 8'h32 : 8'h46, m[1] ? 8'h46 : 8'h3a);
			repeat (6) @(posedge sys_clk);
			sys_rst <= 1'b0;
			tick(2);
			chk(path_fet_en_q, pp);
			rd_reg(CSC_STATUS_ADDR);
			chk(rv[5:4], {hw, pp});
			chk(in_lim_q, CSC_DEF_INPUT_LIMIT);
			chk(chg_volt_q, CSC_DEF_VOLT);
			tick(3);
			chk(dev_on_q, 1'b0);
			if (!hw)
				chk({reg_en_q, chg_en_q}, {pp, 1'b1});
			if (hw) begin
				// ac charger, then a low battery, start supply while off
				@(posedge sys_clk);
				plug <= 2'h3;
				tick(3);
				chk({reg_en_q, chg_en_q}, {pp, 1'b1});
				@(posedge sys_clk);
				plug <= 2'h1;
				lv(m[1] ? 8'h32 : 8'h46, 8'h30);
				tick(3);
				chk({reg_en_q, chg_en_q}, {pp, 1'b1});
			end
			lv(8'h46, 8'h46);
			wait_on(1'b1);
			tick(2);
			if (hw)
				chk({reg_en_q, chg_en_q}, 2'b00);
			wr_reg(CSC_CTRL_ADDR, 32'h3);
			tick(3);
			chk({reg_en_q, chg_en_q}, {pp, 1'b1});
			rd_reg(CSC_STATUS_ADDR);
			chk(rv[4:0], {pp, 1'b1, pp, 2'b01});
			tick(1);
			chk(rdata, 32'h0);
			rd_reg(8'h20);
			chk(rv, 32'h0);
			if (m == 3)
				codes();
			// undervoltage, refused restart, lockout, host clear
			@(posedge sys_clk);
			plug <= 2'h2;
			lv(8'h1e, 8'h1e);
			wait_on(1'b0);
			tick(2);
			chk(fallback_q, 1'b1);
			lv(8'h46, 8'h32);
			tick(4);
			chk(dev_on_q, 1'b0);
			lv(8'h46, 8'h3a);
			tick(4);
			chk(dev_on_q, pp);
			lv(8'h46, 8'h46);
			wait_on(1'b1);
			chk(fallback_q, 1'b1);
			lv(8'h1e, 8'h1e);
			wait_on(1'b0);
			tick(3);
			chk({reg_en_q, chg_en_q}, 2'b00);
			lv(8'h46, 8'h46);
			wait_on(1'b1);
			wr_reg(CSC_CTRL_ADDR, 32'h8);
			tick(2);
			chk(fallback_q, 1'b0);
		end
		wrap_up();
	end
endmodule
